// file: hw/timer3_auto_reload.sv
// Auto-reload timer with 16-bit and split 8-bit modes and its special function registers.
//
// Operation
// - Split bit set: two 8-bit counters, each reloading from its own reload byte.
// - Split bit clear: one 16-bit counter with automatic reload.
// - In 16-bit mode the timer counts only while the run bit is one.
// - In split mode run bit gates only the high byte.
// - Select 00: external tick is system clock over twelve, capture is comparator.
// - Select 01: oscillator over eight is both external tick and capture.
// - Select 11: comparator is external tick, oscillator over eight is capture.
// - Split mode: one source select, per-byte choice bits pick it or system clock.
// - External count sources are synchronised to the system clock.
// - Reload low byte register, read/write, resets to zero.
// - Reload high byte register, read/write, resets to zero.
// - Count low register holds low half or the whole low 8-bit count.
// - High overflow flag set on high byte wrap; hardware never clears it.
// - Low overflow flag set on any low byte wrap; software clears it.
// - Low overflow with its enable and timer interrupts enabled requests interrupt.
`timescale 1ns/1ps
`default_nettype none
module timer3_auto_reload (
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    input  wire timer3_pkg::reg_req_t req_in,
    input  wire logic                 ext_osc_in,
    input  wire logic                 comparator1_in,
    input  wire logic                 timer_irq_enable_in,
    output logic [7:0]                read_data_out,
    output logic                      irq_out,
    output logic                      capture_tick_out
);
    logic [7:0] reload_value_low;
    logic [7:0] reload_value_high;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] control;
    logic [1:0] clock_choice;
    logic [7:0] read_data;
    logic [7:0] next_reload_value_low;
    logic [7:0] next_reload_value_high;
    logic [7:0] next_count_low_byte;
    logic [7:0] next_count_high_byte;
    logic [7:0] next_control;
    logic [1:0] next_clock_choice;
    logic [7:0] next_read_data;
    logic       ext_tick;
    logic       split_mode_select;
    logic       run_control;
    logic       high_byte_clock_choice;
    logic       low_byte_clock_choice;
    logic       low_tick;
    logic       high_tick;
    logic       low_wrap;
    logic       high_wrap;
    logic       wr;

    timer3_clock_source timer3_clock_source_inst (
        .clk_in              (clk_in),
        .rst_n_in            (rst_n_in),
        .ext_clock_select_in (control[1:0]),
        .ext_osc_in          (ext_osc_in),
        .comparator1_in      (comparator1_in),
        .ext_tick_out        (ext_tick),
        .capture_tick_out    (capture_tick_out)
    );

    assign split_mode_select      = control[timer3_pkg::SPLIT_BIT];
    assign run_control            = control[timer3_pkg::RUN_BIT];
    assign high_byte_clock_choice = clock_choice[1];
    assign low_byte_clock_choice  = clock_choice[0];
    assign wr                     = req_in.write;

    always_comb
    begin
        next_reload_value_low  = reload_value_low;
        next_reload_value_high = reload_value_high;
        next_count_low_byte    = count_low_byte;
        next_count_high_byte   = count_high_byte;
        next_control           = control;
        next_clock_choice      = clock_choice;
        low_tick               = 1'b0;
        high_tick              = 1'b0;
        low_wrap               = 1'b0;
        high_wrap              = 1'b0;

        if (split_mode_select)
        begin
            // Each byte picks system clock or the selected external tick.
            low_tick  = low_byte_clock_choice ? 1'b1 : ext_tick;
            high_tick = (high_byte_clock_choice ? 1'b1 : ext_tick) && run_control;
            low_wrap  = low_tick && (count_low_byte == timer3_pkg::BYTE_MAX);
            high_wrap = high_tick && (count_high_byte == timer3_pkg::BYTE_MAX);
            if (low_tick)
                next_count_low_byte = low_wrap ? reload_value_low : count_low_byte + 8'h01;
            if (high_tick)
                next_count_high_byte = high_wrap ? reload_value_high
                                                 : count_high_byte + 8'h01;
        end
        else
        begin
            // Whole-counter mode uses the low-byte choice bit as its clock choice.
            low_tick  = (low_byte_clock_choice ? 1'b1 : ext_tick) && run_control;
            low_wrap  = low_tick && (count_low_byte == timer3_pkg::BYTE_MAX);
            high_wrap = low_wrap && (count_high_byte == timer3_pkg::BYTE_MAX);
            if (high_wrap)
            begin
                next_count_low_byte  = reload_value_low;
                next_count_high_byte = reload_value_high;
            end
            else if (low_tick)
            begin
                next_count_low_byte = count_low_byte + 8'h01;
                if (low_wrap)
                    next_count_high_byte = count_high_byte + 8'h01;
            end
        end

        if (wr)
        begin
            unique case (req_in.addr)
                timer3_pkg::RELOAD_LOW_ADDR:  next_reload_value_low  = req_in.data;
                timer3_pkg::RELOAD_HIGH_ADDR: next_reload_value_high = req_in.data;
                timer3_pkg::COUNT_LOW_ADDR:   next_count_low_byte    = req_in.data;
                timer3_pkg::COUNT_HIGH_ADDR:  next_count_high_byte   = req_in.data;
                timer3_pkg::CONTROL_ADDR:     next_control           = req_in.data;
                timer3_pkg::CLOCK_CTRL_ADDR:
                    next_clock_choice = {req_in.data[timer3_pkg::HIGH_CHOICE_BIT],
                                         req_in.data[timer3_pkg::LOW_CHOICE_BIT]};
                default:
                begin
                end
            endcase
        end
        // A wrap in the same cycle as a software clear keeps the flag set.
        if (high_wrap)
            next_control[timer3_pkg::HIGH_FLAG_BIT] = 1'b1;
        if (low_wrap)
            next_control[timer3_pkg::LOW_FLAG_BIT] = 1'b1;

        next_read_data = 8'h00;
        if (req_in.read)
        begin
            unique case (req_in.addr)
                timer3_pkg::RELOAD_LOW_ADDR:  next_read_data = reload_value_low;
                timer3_pkg::RELOAD_HIGH_ADDR: next_read_data = reload_value_high;
                timer3_pkg::COUNT_LOW_ADDR:   next_read_data = count_low_byte;
                timer3_pkg::COUNT_HIGH_ADDR:  next_read_data = count_high_byte;
                timer3_pkg::CONTROL_ADDR:     next_read_data = control;
                timer3_pkg::CLOCK_CTRL_ADDR:  next_read_data = {clock_choice, 6'h00};
                default:                      next_read_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            reload_value_low  <= timer3_pkg::RESET_BYTE;
            reload_value_high <= timer3_pkg::RESET_BYTE;
            count_low_byte    <= timer3_pkg::RESET_BYTE;
            count_high_byte   <= timer3_pkg::RESET_BYTE;
            control           <= timer3_pkg::RESET_BYTE;
            clock_choice      <= timer3_pkg::RESET_BYTE[1:0];
            read_data         <= timer3_pkg::RESET_BYTE;
        end
        else
        begin
            reload_value_low  <= next_reload_value_low;
            reload_value_high <= next_reload_value_high;
            count_low_byte    <= next_count_low_byte;
            count_high_byte   <= next_count_high_byte;
            control           <= next_control;
            clock_choice      <= next_clock_choice;
            read_data         <= next_read_data;
        end
    end

    assign read_data_out = read_data;
    // Interrupt request follows the low flag while both enables are set.
    assign irq_out = control[timer3_pkg::LOW_FLAG_BIT]
                     && control[timer3_pkg::LOW_IRQ_EN_BIT] && timer_irq_enable_in;

    a_run_stop : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!run_control && !split_mode_select && !wr)
        |=> $stable(count_low_byte) && $stable(count_high_byte))
        else $error("counter moved while stopped");
    a_split_low_free : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (split_mode_select && low_byte_clock_choice && !wr
         && count_low_byte != 8'hFF)
        |=> count_low_byte == $past(count_low_byte) + 8'h01)
        else $error("low byte did not count in split mode");
    a_split_high_held : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (split_mode_select && !run_control && !wr) |=> $stable(count_high_byte))
        else $error("high byte counted with run bit clear");
    a_split_reload : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (split_mode_select && low_tick && count_low_byte == 8'hFF && !wr)
        |=> count_low_byte == $past(reload_value_low))
        else $error("low byte did not reload");
    a_full_reload : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!split_mode_select && high_wrap && !wr)
        |=> count_low_byte == $past(reload_value_low)
            && count_high_byte == $past(reload_value_high))
        else $error("16-bit counter did not reload");
    a_high_flag_set : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        high_wrap |=> control[timer3_pkg::HIGH_FLAG_BIT])
        else $error("high overflow flag not set");
    a_low_flag_set : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        low_wrap |=> control[timer3_pkg::LOW_FLAG_BIT])
        else $error("low overflow flag not set");
    a_flag_sticky : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (control[timer3_pkg::LOW_FLAG_BIT] && !wr) |=> control[timer3_pkg::LOW_FLAG_BIT])
        else $error("low overflow flag cleared by hardware");
    a_irq_follow : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (low_wrap && control[timer3_pkg::LOW_IRQ_EN_BIT] && !wr && timer_irq_enable_in)
        |=> irq_out || !timer_irq_enable_in)
        else $error("interrupt not requested on low overflow");
    a_reload_write : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wr && req_in.addr == timer3_pkg::RELOAD_LOW_ADDR)
        |=> reload_value_low == $past(req_in.data))
        else $error("reload low write lost");
endmodule : timer3_auto_reload
`default_nettype wire

// file: inc/timer3_pkg.sv
// Package with register map, field layout, reset values and types for the auto-reload timer.
`default_nettype none
package timer3_pkg;
    localparam logic [7:0] RELOAD_LOW_ADDR   = 8'h92;
    localparam logic [7:0] RELOAD_HIGH_ADDR  = 8'h93;
    localparam logic [7:0] COUNT_LOW_ADDR    = 8'h94;
    localparam logic [7:0] COUNT_HIGH_ADDR   = 8'h95;
    localparam logic [7:0] CONTROL_ADDR      = 8'h91;
    localparam logic [7:0] CLOCK_CTRL_ADDR   = 8'h8E;
    localparam logic [7:0] RESET_BYTE        = 8'h00;
    localparam logic [7:0] BYTE_MAX          = 8'hFF;
    localparam int         HIGH_FLAG_BIT     = 7;
    localparam int         LOW_FLAG_BIT      = 6;
    localparam int         LOW_IRQ_EN_BIT    = 5;
    localparam int         CAPTURE_EN_BIT    = 4;
    localparam int         SPLIT_BIT         = 3;
    localparam int         RUN_BIT           = 2;
    localparam int         HIGH_CHOICE_BIT   = 7;
    localparam int         LOW_CHOICE_BIT    = 6;
    localparam int         SYSTEM_CLOCK_DIV  = 12;
    localparam int         EXTOSC_DIV        = 8;
    localparam logic [1:0] SEL_SYSDIV        = 2'b00;
    localparam logic [1:0] SEL_EXTOSC        = 2'b01;
    localparam logic [1:0] SEL_RESERVED      = 2'b10;
    localparam logic [1:0] SEL_COMPARATOR    = 2'b11;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_req_t;
endpackage : timer3_pkg
`default_nettype wire

// file: hw/timer3_clock_source.sv
// External count source selection with synchronisers and prescalers.
`timescale 1ns/1ps
`default_nettype none
module timer3_clock_source (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [1:0] ext_clock_select_in,
    input  wire logic       ext_osc_in,
    input  wire logic       comparator1_in,
    output logic            ext_tick_out,
    output logic            capture_tick_out
);
    logic [1:0] osc_sync;
    logic [1:0] cmp_sync;
    logic       osc_last;
    logic       cmp_last;
    logic [3:0] sys_div;
    logic [2:0] osc_div;
    logic [1:0] next_osc_sync;
    logic [1:0] next_cmp_sync;
    logic [3:0] next_sys_div;
    logic [2:0] next_osc_div;
    logic       sys_tick;
    logic       osc_tick;
    logic       cmp_tick;

    // Pins pass two flops; only the second stage feeds edge detection.
    always_comb
    begin
        next_osc_sync = {osc_sync[0], ext_osc_in};
        next_cmp_sync = {cmp_sync[0], comparator1_in};
        sys_tick      = (sys_div == 4'(timer3_pkg::SYSTEM_CLOCK_DIV - 1));
        next_sys_div  = sys_tick ? 4'h0 : sys_div + 4'h1;
        osc_tick      = osc_sync[1] && !osc_last
                        && (osc_div == 3'(timer3_pkg::EXTOSC_DIV - 1));
        next_osc_div  = (osc_sync[1] && !osc_last) ? osc_div + 3'h1 : osc_div;
        cmp_tick      = cmp_sync[1] && !cmp_last;
        unique case (ext_clock_select_in)
            timer3_pkg::SEL_SYSDIV:
            begin
                ext_tick_out     = sys_tick;
                capture_tick_out = cmp_tick;
            end
            timer3_pkg::SEL_EXTOSC:
            begin
                ext_tick_out     = osc_tick;
                capture_tick_out = osc_tick;
            end
            timer3_pkg::SEL_COMPARATOR:
            begin
                ext_tick_out     = cmp_tick;
                capture_tick_out = osc_tick;
            end
            default:
            begin
                // Reserved selection produces no ticks.
                ext_tick_out     = 1'b0;
                capture_tick_out = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            osc_sync <= 2'b00;
            cmp_sync <= 2'b00;
            osc_last <= 1'b0;
            cmp_last <= 1'b0;
            sys_div  <= 4'h0;
            osc_div  <= 3'h0;
        end
        else
        begin
            osc_sync <= next_osc_sync;
            cmp_sync <= next_cmp_sync;
            osc_last <= osc_sync[1];
            cmp_last <= cmp_sync[1];
            sys_div  <= next_sys_div;
            osc_div  <= next_osc_div;
        end
    end

    // The divider runs freely, so its period holds whatever source is selected later.
    a_sysdiv_period : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        sys_tick |=> !sys_tick [*8] ##4 sys_tick)
        else $error("system clock divider period wrong");
    a_reserved_quiet : assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ext_clock_select_in == 2'b10) |-> !ext_tick_out)
        else $error("reserved selection produced a tick");
endmodule : timer3_clock_source
`default_nettype wire

// file: bench/timer3_auto_reload_tb.sv
// Self-checking testbench for the auto-reload timer and its registers.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module timer3_auto_reload_tb;
    logic                 clk_in = 1'b0;
    logic                 rst_n_in = 1'b0;
    timer3_pkg::reg_req_t req = '0;
    logic                 ext_osc_in = 1'b0;
    logic                 comparator1_in = 1'b0;
    logic                 timer_irq_enable_in = 1'b0;
    logic [7:0]           read_data_out;
    logic                 irq_out;
    logic                 capture_tick_out;
    int                   err_count = 0;
    int                   cmp_count = 0;
    int                   cap_n = 0;
    logic [7:0]           d;
    logic [7:0]           keep;

    timer3_auto_reload timer3_auto_reload_inst (
        .clk_in              (clk_in),
        .rst_n_in            (rst_n_in),
        .req_in              (req),
        .ext_osc_in          (ext_osc_in),
        .comparator1_in      (comparator1_in),
        .timer_irq_enable_in (timer_irq_enable_in),
        .read_data_out       (read_data_out),
        .irq_out             (irq_out),
        .capture_tick_out    (capture_tick_out)
    );

    always #2.5 clk_in = ~clk_in;

    // Capture pulses stand one cycle, so they are counted at every edge.
    always @(posedge clk_in)
        if (capture_tick_out === 1'b1)
            cap_n <= cap_n + 1;

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_in) #1 req = '{write: 1'b1, read: 1'b0, addr: a, data: v};
        @(posedge clk_in) #1 req = '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_in) #1 req = '{write: 1'b0, read: 1'b1, addr: a, data: 8'h00};
        @(posedge clk_in) #1 req = '0;
        v = read_data_out;
    endtask : rd

    task automatic pulses(input bit on_osc, input int n);
        repeat (n)
        begin
            @(posedge clk_in) #1 if (on_osc) ext_osc_in = 1'b1; else comparator1_in = 1'b1;
            repeat (4) @(posedge clk_in);
            #1 ext_osc_in = 1'b0;
            comparator1_in = 1'b0;
            repeat (4) @(posedge clk_in);
        end
    endtask : pulses

    task automatic t_reset();
        rd(8'h92, d); `CHK(d, 8'h00)
        rd(8'h93, d); `CHK(d, 8'h00)
        rd(8'h94, d); `CHK(d, 8'h00)
        rd(8'h90, d); `CHK(d, 8'h00)
        wr(8'h92, 8'h5A);
        wr(8'h93, 8'hA5);
        wr(8'h90, 8'hFF);
        rd(8'h92, d); `CHK(d, 8'h5A)
        rd(8'h93, d); `CHK(d, 8'hA5)
        wr(8'h94, 8'hC3);
        rd(8'h94, d); `CHK(d, 8'hC3)
    endtask : t_reset

    task automatic t_run16();
        wr(8'h8E, 8'h40);
        wr(8'h92, 8'h34);
        wr(8'h93, 8'h12);
        wr(8'h94, 8'hFE);
        wr(8'h95, 8'hFF);
        repeat (6) @(posedge clk_in);
        rd(8'h94, d); `CHK(d, 8'hFE)
        wr(8'h91, 8'h04);
        repeat (20) @(posedge clk_in);
        wr(8'h91, 8'h00);
        repeat (2) @(posedge clk_in);
        rd(8'h95, d); `CHK(d, 8'h12)
        rd(8'h94, d); `CHK((d >= 8'h34) && (d < 8'h60), 1'b1)
        rd(8'h94, keep);
        rd(8'h94, d); `CHK(d, keep)
    endtask : t_run16

    task automatic t_flags16();
        wr(8'h94, 8'hFE);
        wr(8'h95, 8'hFF);
        wr(8'h91, 8'h04);
        repeat (10) @(posedge clk_in);
        wr(8'h8E, 8'h00);
        rd(8'h91, d);
        `CHK(d[7], 1'b1)
        `CHK(d[6], 1'b1)
        repeat (4) @(posedge clk_in);
        rd(8'h91, d); `CHK(d[7:6], 2'b11)
        wr(8'h91, 8'h00);
    endtask : t_flags16

    task automatic t_split();
        timer_irq_enable_in = 1'b1;
        wr(8'h8E, 8'hC0);
        wr(8'h92, 8'h80);
        wr(8'h93, 8'h20);
        wr(8'h94, 8'hF0);
        wr(8'h95, 8'h10);
        wr(8'h91, 8'h2A);
        repeat (40) @(posedge clk_in);
        wr(8'h8E, 8'h00);
        rd(8'h91, d);
        `CHK(d[7:6], 2'b01)
        rd(8'h95, d); `CHK(d, 8'h10)
        rd(8'h94, keep); `CHK((keep >= 8'h80) && (keep < 8'hC0), 1'b1)
        `CHK(irq_out, 1'b1)
        @(posedge clk_in) #1 timer_irq_enable_in = 1'b0;
        @(posedge clk_in) #1 `CHK(irq_out, 1'b0)
        wr(8'h91, 8'h0A);
        timer_irq_enable_in = 1'b1;
        @(posedge clk_in) #1 `CHK(irq_out, 1'b0)
        wr(8'h95, 8'hFE);
        wr(8'h8E, 8'h80);
        wr(8'h91, 8'h0E);
        repeat (30) @(posedge clk_in);
        wr(8'h8E, 8'h00);
        rd(8'h91, d); `CHK(d[7:6], 2'b10)
        rd(8'h95, d); `CHK((d >= 8'h20) && (d < 8'h40), 1'b1)
        rd(8'h94, d); `CHK(d, keep)
        wr(8'h91, 8'h00);
        timer_irq_enable_in = 1'b0;
    endtask : t_split

    task automatic t_select(input logic [1:0] sel, input int lo, input int hi,
                            input int cap);
        int c0;
        wr(8'h8E, 8'h00);
        wr(8'h92, 8'h00);
        wr(8'h93, 8'h00);
        wr(8'h94, 8'h00);
        wr(8'h95, 8'h00);
        c0 = cap_n;
        wr(8'h91, {6'b0000_01, sel});
        case (sel)
            2'b01: pulses(1'b1, 64);
            2'b11: pulses(1'b0, 5);
            2'b00: begin pulses(1'b0, 3); repeat (96) @(posedge clk_in); end
            default: begin pulses(1'b1, 16); pulses(1'b0, 3); end
        endcase
        repeat (6) @(posedge clk_in);
        wr(8'h91, 8'h00);
        rd(8'h94, d); `CHK((d >= lo) && (d <= hi), 1'b1)
        `CHK(((cap_n - c0) >= cap - 1) && ((cap_n - c0) <= cap), 1'b1)
    endtask : t_select

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    initial
    begin
        #(5 * 40000);
        err_count++;
        summarize();
    end

    initial
    begin
        repeat (4) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        t_reset();
        t_run16();
        t_flags16();
        t_split();
        t_select(2'b01, 7, 8, 8);
        t_select(2'b11, 5, 5, 0);
        t_select(2'b00, 9, 11, 3);
        t_select(2'b10, 0, 0, 0);
        summarize();
    end
endmodule : timer3_auto_reload_tb
`default_nettype wire
